//--- design/fsw_cfg.svh
// constants of the rf frequency sweep sequencer: widths, resets, timing
// assumes one 40 mhz system clock shared by every module of the block
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define FSW_CLK_HZ 40000000
`define FSW_US_HZ 1000000
`define FSW_US_CYC (`FSW_CLK_HZ / `FSW_US_HZ)

// ---------------------------------------------------------------------
// widths, depths and resets
// ---------------------------------------------------------------------
`define FSW_FREQ_W 32
`define FSW_IDX_W 6
`define FSW_IDX_MAX 6'h3f
`define FSW_PCT_DIV 40'h64
`define FSW_FREQ_RST 32'h0000_0000
`define FSW_ACT_FREQ 4'h1
`define FSW_ACT_LEVEL 4'h2
`define FSW_ACT_LF 4'h4
`define FSW_ACT_LIST 4'h8
`define FSW_ACT_RST 4'h0
`define FSW_RAMP_RST 16'h0000

`endif

//--- design/fsw_pkg.sv
// types of the rf frequency sweep sequencer
// assumes widths that match fsw_cfg.svh; no number is taken from it
package fsw_pkg;

  typedef enum logic [2:0] {
    FSW_MODE_AUTO = 3'b000,
    FSW_MODE_SINGLE = 3'b001,
    FSW_MODE_STEP = 3'b010,
    FSW_MODE_EXT_SINGLE = 3'b011,
    FSW_MODE_EXT_STEP = 3'b100,
    FSW_MODE_EXT_START_STOP = 3'b101
  } fsw_mode_type;

  typedef enum logic [1:0] {
    FSW_ST_IDLE = 2'b00,
    FSW_ST_RUN = 2'b01,
    FSW_ST_HALT = 2'b10
  } fsw_state_type;

  typedef struct packed {
    logic [2:0] mode_q;
    fsw_state_type st;
    logic [3:0] active;
    logic [31:0] freq;
    logic [5:0] idx;
    logic falling;
    logic [5:0] presc;
    logic [15:0] dwell_cnt;
    logic [31:0] start_eff;
    logic [31:0] stop_eff;
    logic [31:0] center_eff;
    logic [31:0] span_eff;
  } fsw_seq_state_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pulse;
  } fsw_trig_state_type;

  typedef struct packed {
    logic signed [15:0] ramp;
  } fsw_ramp_state_type;

endpackage

//--- design/fsw_if.sv
// signals between the sequencer and its trigger and ramp helpers
// assumes all three sit on the same clock
interface fsw_if;
  logic trig_pulse;
  logic [31:0] freq;
  logic [31:0] start_freq;
  logic [31:0] stop_freq;
  logic signed [15:0] volt_start;
  logic signed [15:0] volt_stop;
  logic lf_en;
  logic signed [15:0] ramp;

  modport trig (output trig_pulse);
  modport ramp_gen (input freq, start_freq, stop_freq, volt_start,
    volt_stop, lf_en, output ramp);
  modport seq (input trig_pulse, ramp, output freq, start_freq, stop_freq,
    volt_start, volt_stop, lf_en);
endinterface

//--- design/fsw_trig.sv
// external trigger pin conditioning: two-stage sync, edge select, pulse
// assumes the pin is asynchronous to clk
`include "fsw_cfg.svh"

module fsw_trig (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic trig_pin,
  input wire logic slope_neg,
  fsw_if.trig bus
);

  fsw_pkg::fsw_trig_state_type s_reg;
  fsw_pkg::fsw_trig_state_type s_next;

  // ---------------------------------------------------------------------
  // edge detect
  // ---------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = trig_pin;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = s_reg.sync2;
    // edge taken only after the second stage, never from sync1
    s_next.pulse = slope_neg ? (~s_reg.sync2 & s_reg.prev)
                             : (s_reg.sync2 & ~s_reg.prev);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '0;
    else if (ce)
      s_reg <= s_next;
  end

  assign bus.trig_pulse = s_reg.pulse & ce;

endmodule // fsw_trig

//--- design/fsw_ramp.sv
// sweep voltage ramp, linear in frequency between start and stop
// assumes start and stop from the sequencer are already consistent
`include "fsw_cfg.svh"

module fsw_ramp (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  fsw_if.ramp_gen bus
);

  fsw_pkg::fsw_ramp_state_type s_reg;
  fsw_pkg::fsw_ramp_state_type s_next;
  logic signed [32:0] pos;
  logic signed [32:0] span;
  logic signed [16:0] vdiff;
  logic signed [49:0] prod;
  logic signed [49:0] quot;

  // ---------------------------------------------------------------------
  // interpolation
  // ---------------------------------------------------------------------
  // a combinational divide; slow path, but the ramp only feeds a dac
  always_comb
  begin
    pos = $signed({1'b0, bus.freq}) - $signed({1'b0, bus.start_freq});
    span = $signed({1'b0, bus.stop_freq}) - $signed({1'b0, bus.start_freq});
    vdiff = 17'(bus.volt_stop) - 17'(bus.volt_start);
    prod = 50'(pos) * 50'(vdiff);
    quot = (span == 33'sd0) ? 50'sd0 : prod / 50'(span);
    s_next = s_reg;
    if (bus.lf_en)
      s_next.ramp = 16'(50'(bus.volt_start) + quot);
    else
      s_next.ramp = `FSW_RAMP_RST;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_reg.ramp <= `FSW_RAMP_RST;
    else if (ce)
      s_reg <= s_next;
  end

  assign bus.ramp = s_reg.ramp;

endmodule // fsw_ramp

//--- design/fsw_seq.sv
// rf frequency sweep sequencer top: modes, stepping, dwell, range
// assumes host controls on clk; only trig_pin is asynchronous
`include "fsw_cfg.svh"

module fsw_seq (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [2:0] mode,
  input wire logic en_freq_sweep,
  input wire logic en_level_sweep,
  input wire logic en_lf_sweep,
  input wire logic en_list,
  input wire logic use_center,
  input wire logic [31:0] start_freq,
  input wire logic [31:0] stop_freq,
  input wire logic [31:0] center_freq,
  input wire logic [31:0] span_freq,
  input wire logic spacing_log,
  input wire logic shape_triangle,
  input wire logic [31:0] step_lin,
  input wire logic [6:0] step_log_pct,
  input wire logic [15:0] dwell_us,
  input wire logic cmd_exec_single,
  input wire logic cmd_reset,
  input wire logic cmd_up,
  input wire logic cmd_down,
  input wire logic trig_pin,
  input wire logic slope_neg,
  input wire logic lf_en,
  input wire logic signed [15:0] volt_start,
  input wire logic signed [15:0] volt_stop,
  output logic [31:0] cur_freq,
  output logic running,
  output logic halted,
  output logic [3:0] active_sel,
  output logic [31:0] eff_start,
  output logic [31:0] eff_stop,
  output logic [31:0] eff_center,
  output logic [31:0] eff_span,
  output logic signed [15:0] ramp_out
);

  fsw_pkg::fsw_seq_state_type s_reg;
  fsw_pkg::fsw_seq_state_type s_next;
  fsw_if bus ();

  // visited sweep points; lets the return slope and manual down
  // retrace the exact rising points instead of recomputing them
  logic [31:0] hist [0:63];
  logic h_we;
  logic [5:0] h_addr;
  logic [31:0] h_data;
  logic [31:0] hist_rd;
  logic [31:0] nxt_pt;
  logic up_dir;
  logic at_top;
  logic one_shot;
  logic do_step;
  logic trig;
  logic freq_on;
  logic [15:0] dwell_min;

  fsw_trig u_trig (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .trig_pin(trig_pin),
    .slope_neg(slope_neg),
    .bus(bus)
  );

  fsw_ramp u_ramp (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .bus(bus)
  );

  // ---------------------------------------------------------------------
  // next sweep point
  // ---------------------------------------------------------------------
  function automatic logic [31:0] step_pt(
    input logic [31:0] f,
    input logic [31:0] stop,
    input logic up,
    input logic log_sp,
    input logic [31:0] lin,
    input logic [6:0] pct
  );
    logic [39:0] wide;
    logic [39:0] nx;
    logic [39:0] stop_w;
    begin
      stop_w = {8'h00, stop};
      wide = {8'h00, f} * {33'h0, pct};
      if (log_sp && up)
        nx = {8'h00, f} + wide / `FSW_PCT_DIV;
      else if (log_sp)
        nx = ({8'h00, f} * `FSW_PCT_DIV)
             / (`FSW_PCT_DIV + {33'h0, pct});
      else if (up)
        nx = {8'h00, f} + {8'h00, lin};
      else if ({8'h00, f} > stop_w + {8'h00, lin})
        nx = {8'h00, f} - {8'h00, lin};
      else
        nx = stop_w;
      if (up && nx > stop_w)
        nx = stop_w;
      if (!up && nx < stop_w)
        nx = stop_w;
      step_pt = nx[31:0];
    end
  endfunction

  assign hist_rd = hist[s_reg.idx - 6'h01];
  assign up_dir = s_reg.start_eff <= s_reg.stop_eff;
  assign nxt_pt = step_pt(s_reg.freq, s_reg.stop_eff, up_dir, spacing_log,
    step_lin, step_log_pct);
  assign at_top = (s_reg.freq == s_reg.stop_eff)
                  || (s_reg.idx == `FSW_IDX_MAX);
  assign one_shot = (s_reg.mode_q == fsw_pkg::FSW_MODE_SINGLE)
                    || (s_reg.mode_q == fsw_pkg::FSW_MODE_EXT_SINGLE);
  assign trig = bus.trig_pulse;
  assign freq_on = s_reg.active == `FSW_ACT_FREQ;
  assign dwell_min = (dwell_us == 16'h0000) ? 16'h0001 : dwell_us;

  // ---------------------------------------------------------------------
  // dwell pacing
  // ---------------------------------------------------------------------
  // a microsecond prescaler keeps the dwell counter narrow
  always_comb
  begin
    do_step = 1'b0;
    if (s_reg.st == fsw_pkg::FSW_ST_RUN
        && s_reg.presc == 6'(`FSW_US_CYC - 1)
        && s_reg.dwell_cnt + 16'h0001 >= dwell_min)
      do_step = 1'b1;
  end

  // ---------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    h_we = 1'b0;
    h_addr = s_reg.idx + 6'h01;
    h_data = nxt_pt;

    // range bookkeeping: start and stop one register stage behind the host values, center and span two
    if (use_center)
    begin
      s_next.start_eff = center_freq - (span_freq >> 1);
      s_next.stop_eff = center_freq + (span_freq >> 1);
    end
    else
    begin
      s_next.start_eff = start_freq;
      s_next.stop_eff = stop_freq;
    end
    s_next.center_eff = 32'(({1'b0, s_reg.start_eff}
                      + {1'b0, s_reg.stop_eff}) >> 1);
    s_next.span_eff = s_reg.stop_eff - s_reg.start_eff;

    // dwell counters run only while sweeping
    if (s_reg.st == fsw_pkg::FSW_ST_RUN)
    begin
      if (s_reg.presc == 6'(`FSW_US_CYC - 1))
      begin
        s_next.presc = 6'h00;
        s_next.dwell_cnt = do_step ? 16'h0000 : s_reg.dwell_cnt + 16'h0001;
      end
      else
        s_next.presc = s_reg.presc + 6'h01;
    end
    else
    begin
      s_next.presc = 6'h00;
      s_next.dwell_cnt = 16'h0000;
    end

    if (en_freq_sweep || en_level_sweep || en_lf_sweep || en_list)
    begin
      // first enable in priority order wins; one type only
      if (en_freq_sweep)
        s_next.active = `FSW_ACT_FREQ;
      else if (en_level_sweep)
        s_next.active = `FSW_ACT_LEVEL;
      else if (en_lf_sweep)
        s_next.active = `FSW_ACT_LF;
      else
        s_next.active = `FSW_ACT_LIST;
      s_next.st = fsw_pkg::FSW_ST_IDLE;
      s_next.freq = s_reg.start_eff;
      s_next.idx = 6'h00;
      s_next.falling = 1'b0;
      h_we = 1'b1;
      h_addr = 6'h00;
      h_data = s_reg.start_eff;
    end
    else if (mode != s_reg.mode_q)
    begin
      s_next.mode_q = mode;
      s_next.st = fsw_pkg::FSW_ST_IDLE;
      s_next.freq = s_reg.start_eff;
      s_next.idx = 6'h00;
      s_next.falling = 1'b0;
      h_we = 1'b1;
      h_addr = 6'h00;
      h_data = s_reg.start_eff;
    end
    else if (!freq_on)
      s_next.st = fsw_pkg::FSW_ST_IDLE;
    else if (cmd_reset)
    begin
      s_next.st = fsw_pkg::FSW_ST_IDLE;
      s_next.freq = s_reg.start_eff;
      s_next.idx = 6'h00;
      s_next.falling = 1'b0;
      h_we = 1'b1;
      h_addr = 6'h00;
      h_data = s_reg.start_eff;
    end
    else
    begin
      unique case (s_reg.mode_q)
        fsw_pkg::FSW_MODE_STEP:
        begin
          s_next.falling = 1'b0;
          if (cmd_up && !at_top)
          begin
            s_next.freq = nxt_pt;
            s_next.idx = s_reg.idx + 6'h01;
            h_we = 1'b1;
          end
          else if (cmd_down && s_reg.idx != 6'h00)
          begin
            s_next.freq = hist_rd;
            s_next.idx = s_reg.idx - 6'h01;
          end
          // otherwise the command would leave the range: dropped
        end
        fsw_pkg::FSW_MODE_AUTO:
        begin
          if (s_reg.st != fsw_pkg::FSW_ST_RUN)
            s_next.st = fsw_pkg::FSW_ST_RUN;
        end
        fsw_pkg::FSW_MODE_SINGLE:
        begin
          if (cmd_exec_single && s_reg.st == fsw_pkg::FSW_ST_IDLE)
            s_next.st = fsw_pkg::FSW_ST_RUN;
        end
        fsw_pkg::FSW_MODE_EXT_SINGLE:
        begin
          if (trig && s_reg.st == fsw_pkg::FSW_ST_IDLE)
            s_next.st = fsw_pkg::FSW_ST_RUN;
        end
        fsw_pkg::FSW_MODE_EXT_STEP:
        begin
          s_next.st = fsw_pkg::FSW_ST_IDLE;
        end
        fsw_pkg::FSW_MODE_EXT_START_STOP:
        begin
          if (trig)
          begin
            unique case (s_reg.st)
              fsw_pkg::FSW_ST_IDLE:
                s_next.st = fsw_pkg::FSW_ST_RUN;
              fsw_pkg::FSW_ST_RUN:
                s_next.st = fsw_pkg::FSW_ST_HALT;
              fsw_pkg::FSW_ST_HALT:
              begin
                s_next.st = fsw_pkg::FSW_ST_RUN;
                s_next.freq = s_reg.start_eff;
                s_next.idx = 6'h00;
                s_next.falling = 1'b0;
              end
              default:
                s_next.st = fsw_pkg::FSW_ST_IDLE;
            endcase
          end
        end
        default:
          s_next.st = fsw_pkg::FSW_ST_IDLE;
      endcase

      // one sweep step: dwell expiry, or an edge in external step
      if (do_step || (trig
          && s_reg.mode_q == fsw_pkg::FSW_MODE_EXT_STEP))
      begin
        if (s_reg.falling)
        begin
          if (s_reg.idx == 6'h00)
          begin
            if (one_shot)
              s_next.st = fsw_pkg::FSW_ST_IDLE;
            else
            begin
              s_next.falling = 1'b0;
              s_next.freq = nxt_pt;
              s_next.idx = 6'h01;
              h_we = 1'b1;
            end
          end
          else
          begin
            s_next.freq = hist_rd;
            s_next.idx = s_reg.idx - 6'h01;
          end
        end
        else if (at_top)
        begin
          if (shape_triangle && s_reg.idx != 6'h00)
          begin
            s_next.falling = 1'b1;
            s_next.freq = hist_rd;
            s_next.idx = s_reg.idx - 6'h01;
          end
          else if (one_shot)
            s_next.st = fsw_pkg::FSW_ST_IDLE;
          else
          begin
            s_next.freq = s_reg.start_eff;
            s_next.idx = 6'h00;
          end
        end
        else
        begin
          s_next.freq = nxt_pt;
          s_next.idx = s_reg.idx + 6'h01;
          h_we = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // state and point memory
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
      s_reg.freq <= `FSW_FREQ_RST;
      s_reg.active <= `FSW_ACT_RST;
      s_reg.mode_q <= fsw_pkg::FSW_MODE_AUTO;
      s_reg.st <= fsw_pkg::FSW_ST_IDLE;
    end
    else if (ce)
      s_reg <= s_next;
  end

  always_ff @(posedge clk)
  begin
    if (ce && h_we)
      hist[h_addr] <= h_data;
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign bus.freq = s_reg.freq;
  assign bus.start_freq = s_reg.start_eff;
  assign bus.stop_freq = s_reg.stop_eff;
  assign bus.volt_start = volt_start;
  assign bus.volt_stop = volt_stop;
  assign bus.lf_en = lf_en;
  assign cur_freq = s_reg.freq;
  assign running = s_reg.st == fsw_pkg::FSW_ST_RUN;
  assign halted = s_reg.st == fsw_pkg::FSW_ST_HALT;
  assign active_sel = s_reg.active;
  assign eff_start = s_reg.start_eff;
  assign eff_stop = s_reg.stop_eff;
  assign eff_center = s_reg.center_eff;
  assign eff_span = s_reg.span_eff;
  assign ramp_out = bus.ramp;

endmodule // fsw_seq

//--- dv/fsw_trig_src.sv
// partner model: source of the external trigger pin
// assumes fire is called by the bench straight after a rising clk edge
module fsw_trig_src (
  input wire logic clk,
  input wire logic slope_neg,
  output logic trig_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  initial trig_pin = 1'b0;
  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // idle level follows polarity, so a polarity change is never active
  always @(posedge clk) trig_pin <= busy ? !slope_neg : slope_neg;
  // one active edge, level held 4 cycles, twice the minimum
  task automatic fire();
    busy <= 1'b1;
    repeat (4) @(posedge clk);
    busy <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
endmodule // fsw_trig_src

//--- dv/fsw_seq_properties.sv
// checker for the sweep sequencer, bound to fsw_seq
// assumes only the top ports; one clock, async active-low reset
module fsw_seq_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [2:0] mode,
  input wire logic en_freq_sweep,
  input wire logic en_level_sweep,
  input wire logic en_lf_sweep,
  input wire logic en_list,
  input wire logic use_center,
  input wire logic [31:0] center_freq,
  input wire logic [31:0] span_freq,
  input wire logic spacing_log,
  input wire logic [31:0] step_lin,
  input wire logic [15:0] dwell_us,
  input wire logic cmd_exec_single,
  input wire logic cmd_reset,
  input wire logic cmd_up,
  input wire logic lf_en,
  input wire logic signed [15:0] volt_start,
  input wire logic [31:0] cur_freq,
  input wire logic running,
  input wire logic halted,
  input wire logic [3:0] active_sel,
  input wire logic [31:0] eff_start,
  input wire logic [31:0] eff_stop,
  input wire logic signed [15:0] ramp_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic quiet;
  logic man;
  logic [31:0] last_q;
  logic [31:0] since_q;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  assign quiet = ce && !(en_freq_sweep | en_level_sweep | en_lf_sweep
    | en_list) && !cmd_reset;
  assign man = quiet && mode == 3'h2 && active_sel == 4'h1;
  // cycles since cur_freq last moved, for the dwell check
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      since_q <= 32'h0000_0000;
    else
      since_q <= (cur_freq != last_q) ? 32'h0000_0000 : since_q + 32'h1;
  end
  always_ff @(posedge clk) last_q <= cur_freq;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_onehot;
    $onehot0(active_sel);
  endproperty
  property p_sel;
    ce && en_freq_sweep |=> active_sel == 4'h1;
  endproperty
  property p_mchg;
    quiet && active_sel == 4'h1 && mode != $past(mode)
      |=> cur_freq == $past(eff_start);
  endproperty
  property p_border;
    man && $stable(mode) && cmd_up && cur_freq == eff_stop |=> $stable(cur_freq);
  endproperty
  property p_lin;
    man && $stable(mode) && cmd_up && !spacing_log && eff_start < eff_stop
      && cur_freq + step_lin <= eff_stop
      |=> cur_freq == $past(cur_freq) + $past(step_lin);
  endproperty
  property p_rst;
    ce && cmd_reset && active_sel == 4'h1 && mode == $past(mode)
      && !(en_freq_sweep | en_level_sweep | en_lf_sweep | en_list)
      |=> cur_freq == $past(eff_start);
  endproperty
  property p_exec;
    quiet && $stable(mode) && mode == 3'h1 && active_sel == 4'h1
      && cmd_exec_single && !running |=> running;
  endproperty
  property p_ramp;
    lf_en && cur_freq == eff_start && eff_start != eff_stop
      |=> ramp_out == $past(volt_start);
  endproperty
  property p_dwell;
    running && $past(running) && mode < 3'h2 && $changed(cur_freq)
      |-> since_q + 32'h1 >= 32'(dwell_us) * 32'h28;
  endproperty
  property p_center;
    use_center && $stable(use_center) && $stable(center_freq)
      && $stable(span_freq) |=> eff_start == center_freq - (span_freq >> 1);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two types on");
  a_sel: assert property (p_sel) else $error("enable not taken");
  a_mchg: assert property (p_mchg) else $error("no start load");
  a_border: assert property (p_border) else $error("left range");
  a_lin: assert property (p_lin) else $error("bad lin step");
  a_rst: assert property (p_rst) else $error("reset missed");
  a_exec: assert property (p_exec) else $error("exec missed");
  a_ramp: assert property (p_ramp) else $error("ramp start");
  a_dwell: assert property (p_dwell) else $error("step early");
  a_center: assert property (p_center) else $error("bad start");
  c_run: cover property ($rose(running));
  c_halt: cover property ($rose(halted));
  c_border: cover property (cmd_up && cur_freq == eff_stop);
endmodule // fsw_seq_properties

bind fsw_seq fsw_seq_properties u_props (.clk(clk), .resetn(resetn),
  .ce(ce), .mode(mode), .en_freq_sweep(en_freq_sweep),
  .en_level_sweep(en_level_sweep), .en_lf_sweep(en_lf_sweep),
  .en_list(en_list), .use_center(use_center), .center_freq(center_freq),
  .span_freq(span_freq), .spacing_log(spacing_log), .step_lin(step_lin),
  .dwell_us(dwell_us), .cmd_exec_single(cmd_exec_single),
  .cmd_reset(cmd_reset), .cmd_up(cmd_up), .lf_en(lf_en),
  .volt_start(volt_start), .cur_freq(cur_freq), .running(running),
  .halted(halted), .active_sel(active_sel), .eff_start(eff_start),
  .eff_stop(eff_stop), .ramp_out(ramp_out));

//--- dv/rf_frequency_sweep_sequencer_tb.sv
// self-checking bench for the frequency sweep sequencer
// assumes fsw_seq, the trigger source model and the bound checker
module rf_frequency_sweep_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] f_start = 32'h0000_03e8;
  localparam logic [31:0] f_stop = 32'h0000_0578;
  localparam logic [31:0] f_step = 32'h0000_0064;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] mode = 3'h2;
  logic [3:0] e = 4'h0;
  logic [3:0] c = 4'h0;
  logic use_center = 1'b0;
  logic spacing_log = 1'b0;
  logic shape_triangle = 1'b0;
  logic slope_neg = 1'b0;
  logic lf_en = 1'b1;
  logic ce = 1'b1;
  logic [6:0] pct = 7'h0a;
  logic [15:0] dwell = 16'h0001;
  logic signed [15:0] vst = 16'shff9c;
  logic signed [15:0] vsp = 16'sh0064;
  logic [31:0] cur_freq, eff_start, eff_stop, eff_center, eff_span, f;
  logic running, halted, trig_pin;
  logic [3:0] active_sel;
  logic signed [15:0] ramp_out;
  logic [31:0] q[$];
  int fail_count = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  fsw_trig_src tsrc (.clk(clk), .slope_neg(slope_neg), .trig_pin(trig_pin));
  fsw_seq dut (.clk(clk), .resetn(resetn), .ce(ce), .mode(mode),
    .en_freq_sweep(e[0]), .en_level_sweep(e[1]), .en_lf_sweep(e[2]),
    .en_list(e[3]), .use_center(use_center), .start_freq(f_start),
    .stop_freq(f_stop), .center_freq(32'h0000_07d0),
    .span_freq(32'h0000_0258), .spacing_log(spacing_log),
    .shape_triangle(shape_triangle), .step_lin(f_step),
    .step_log_pct(pct), .dwell_us(dwell), .cmd_exec_single(c[0]),
    .cmd_reset(c[1]), .cmd_up(c[2]), .cmd_down(c[3]), .trig_pin(trig_pin),
    .slope_neg(slope_neg), .lf_en(lf_en), .volt_start(vst),
    .volt_stop(vsp), .cur_freq(cur_freq), .running(running),
    .halted(halted), .active_sel(active_sel), .eff_start(eff_start),
    .eff_stop(eff_stop), .eff_center(eff_center), .eff_span(eff_span),
    .ramp_out(ramp_out));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one-cycle pulse on commands and enables, then let the answer land
  task automatic pulse(input logic [3:0] cv, input logic [3:0] ev);
    c <= cv;
    e <= ev;
    cyc(1);
    c <= 4'h0;
    e <= 4'h0;
    cyc(2);
  endtask
  // log every point of one running sweep and compare with the ladder
  task automatic run_wait(input logic tri_on);
    int k;
    q.delete();
    f = cur_freq;
    for (k = 0; k < 1000 && running === 1'b1; k++)
    begin
      cyc(1);
      if (cur_freq !== f)
        q.push_back(cur_freq);
      f = cur_freq;
    end
    chk(32'(q.size()), tri_on ? 32'h8 : 32'h4);
    for (k = 0; k < (tri_on ? 8 : 4); k++)
      chk(q[k], f_start + f_step * 32'(k < 4 ? k + 1 : 7 - k));
  endtask
  task automatic stop_test();
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    cyc(4);
    resetn <= 1'b1;
    cyc(3);
    chk({28'h0, active_sel}, 32'h0);
    for (int k = 3; k >= 0; k--)
    begin
      pulse(4'h0, 4'h1 << k);
      chk({28'h0, active_sel}, 32'h1 << k);
    end
    chk(cur_freq, f_start);
    chk({16'h0, ramp_out}, 32'h0000_ff9c);
    chk(eff_center, 32'h0000_04b0);
    chk(eff_span, 32'h0000_0190);
    pulse(4'h8, 4'h0);
    chk(cur_freq, f_start);
    for (int k = 1; k < 5; k++)
    begin
      pulse(4'h4, 4'h0);
      chk(cur_freq, f_start + f_step * 32'(k));
    end
    chk({16'h0, ramp_out}, 32'h0000_0064);
    pulse(4'h4, 4'h0);
    chk(cur_freq, f_stop);
    pulse(4'h8, 4'h0);
    chk(cur_freq, f_stop - f_step);
    pulse(4'h1, 4'h0);
    chk({31'h0, running}, 32'h0);
    pulse(4'h2, 4'h0);
    chk(cur_freq, f_start);
    spacing_log <= 1'b1;
    f = f_start;
    for (int k = 0; k < 4; k++)
    begin
      pulse(4'h4, 4'h0);
      f = 32'((64'(f) * 64'h6e) / 64'h64);
      if (f > f_stop)
        f = f_stop;
      chk(cur_freq, f);
    end
    spacing_log <= 1'b0;
    mode <= 3'h1;
    cyc(3);
    chk(cur_freq, f_start);
    pulse(4'h1, 4'h0);
    chk({31'h0, running}, 32'h1);
    run_wait(1'b0);
    cyc(60);
    chk(cur_freq, f_stop);
    shape_triangle <= 1'b1;
    pulse(4'h2, 4'h0);
    pulse(4'h1, 4'h0);
    run_wait(1'b1);
    shape_triangle <= 1'b0;
    mode <= 3'h3;
    cyc(3);
    tsrc.fire();
    run_wait(1'b0);
    cyc(100);
    chk(cur_freq, f_stop);
    mode <= 3'h4;
    cyc(3);
    for (int k = 1; k < 5; k++)
    begin
      slope_neg <= (k > 2);
      cyc(6);
      tsrc.fire();
      chk(cur_freq, f_start + f_step * 32'(k));
    end
    slope_neg <= 1'b0;
    mode <= 3'h5;
    cyc(8);
    tsrc.fire();
    chk({31'h0, running}, 32'h1);
    cyc(100);
    tsrc.fire();
    chk({31'h0, halted}, 32'h1);
    f = cur_freq;
    cyc(100);
    chk(cur_freq, f);
    tsrc.fire();
    chk(cur_freq, f_start);
    chk({31'h0, running}, 32'h1);
    use_center <= 1'b1;
    mode <= 3'h0;
    cyc(3);
    chk(eff_start, 32'h0000_06a4);
    chk(eff_stop, 32'h0000_08fc);
    cyc(250);
    chk({31'h0, running}, 32'h1);
    // clock enable low must freeze the sweep across several dwells
    ce <= 1'b0;
    cyc(2);
    f = cur_freq;
    cyc(100);
    chk(cur_freq, f);
    ce <= 1'b1;
    stop_test();
  end
  // watchdog: the sequence needs about 1700 cycles
  initial
  begin
    cyc(20000);
    fail_count++;
    stop_test();
  end
endmodule // rf_frequency_sweep_sequencer_tb
